// ==== bti_top.sv ====
// Board interrupt enables and the slave-mode and master-mode timeout timers.
// Assumes host I/O strobes are one-cycle pulses synchronous to mclk and that
// the condition inputs come from other card logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "bti_map.svh"

// Overview of operation
// RULE_01 - Enabled expansion IRQ sets board flag
// RULE_02 - Enabled master exception sets board flag
// RULE_03 - Enabled terminal count sets status, then flag
// RULE_04 - Disabling terminal count clears its status
// RULE_05 - Enabled bus ownership sets status, then flag
// RULE_06 - Disabling ownership enable clears its status
// RULE_07 - Enabled signal ready sets board flag
// RULE_08 - Hard reset clears all five enables
// RULE_09 - Offset 10h loads slave hold limit
// RULE_10 - Slave expiry releases bus after transfer
// RULE_11 - Software writes low byte, then high
// RULE_12 - Software writes timer control before counts
// RULE_13 - Slave limit is count times 100 ns
// RULE_14 - Offset 12h loads master stall limit
// RULE_15 - Master expiry aborts host cycle, asks retry
// RULE_16 - Expansion transfer continues after the abort
// RULE_17 - Master limit is count times 100 ns
// RULE_18 - Board interrupt follows the enable equation
// RULE_19 - Control byte selects timer, mode 110100
// RULE_20 - Timers restart on grant or cycle start
// RULE_21 - Timers count ticks down to zero
module bti_top
    import bti_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Host I/O port
    input  wire logic        ioWrite,
    input  wire logic        ioRead,
    input  wire logic [4:0]  ioAddr,
    input  wire logic [7:0]  ioWrData,
    output logic      [7:0]  ioRdData,
    // Status conditions
    input  wire logic        sigReadyCond,
    input  wire logic        tcEvent,
    input  wire bti_exc_t    exceptions,
    input  wire logic        expansionIrq,
    input  wire logic        busOwnedCond,
    input  wire logic        pcReqEvent,
    // Host bus mastership (slave-mode cycles)
    input  wire logic        hostGrant,
    input  wire logic        slaveXferBusy,
    output logic             hostBusRelease,
    // Host cycles toward the expansion bus (master mode)
    input  wire logic        hostCycleStart,
    input  wire logic        masterXferBusy,
    output logic             hostAbortRetry,
    // Board interrupt line
    output logic             boardIrq,
    output logic             boardIrqOe
);

    bti_ctrl_t   ctrl_reg;
    bti_sel_t    tgt_reg;
    bti_load_t   ld_reg;
    logic [7:0]  lowByte_reg;
    logic [15:0] slaveLimit_reg;
    logic [15:0] masterLimit_reg;
    logic        tcStatus_reg;
    logic        ownStatus_reg;
    logic        pcReqStatus_reg;
    logic        boardFlag_reg;
    logic        flag_next;
    logic        grantDly_reg;
    logic        aborted_reg;
    logic        slaveTo_reg;
    logic        masterTo_reg;
    logic        tick;
    logic        slaveExpired;
    logic        masterExpired;
    logic        excAny;
    logic        ctrlWr;
    logic        tmrCtrlWr;
    logic        slaveWr;
    logic        masterWr;
    logic [15:0] statusWord;

    // Count word from the two byte writes, high byte weighted by 256
    function automatic logic [15:0] joinBytes(input logic [7:0] hi, input logic [7:0] lo);
        joinBytes = {hi, lo};
    endfunction : joinBytes

    // Address decode of host writes
    assign ctrlWr    = ioWrite && ioAddr == `BTI_OFS_CTRL;
    assign tmrCtrlWr = ioWrite && ioAddr == `BTI_OFS_TMR_CTRL;
    assign slaveWr   = ioWrite && ioAddr == `BTI_OFS_SLAVE_TMR;    // RULE_09
    assign masterWr  = ioWrite && ioAddr == `BTI_OFS_MASTER_TMR;   // RULE_14
    assign excAny    = |exceptions;

    // Board control byte; hard reset leaves every enable off
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= bti_ctrl_t'(`BTI_CTRL_RST);   // RULE_08
        else if (ctrlWr)
            ctrl_reg <= bti_ctrl_t'(ioWrData);
    end

    // Count loading: control write arms a timer, then low and high bytes.
    // A bad mode field or a system-controller or reserved select loads nothing
    // and drops any load in progress, since that timer is not held here.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ld_reg      <= LD_IDLE;
            tgt_reg     <= SEL_SLAVE;
            lowByte_reg <= `BTI_BYTE_RST;
        end
        else if (tmrCtrlWr)
        begin
            tgt_reg <= bti_sel_t'(ioWrData[`BTI_SEL_MSB:`BTI_SEL_LSB]);   // RULE_19
            if (ioWrData[`BTI_MODE_MSB:0] == `BTI_MODE_VAL && !ioWrData[`BTI_SEL_MSB])
                ld_reg <= LD_LOW;   // RULE_12
            else
                ld_reg <= LD_IDLE;
        end
        else if ((slaveWr && tgt_reg == SEL_SLAVE) || (masterWr && tgt_reg == SEL_MASTER))
        begin
            unique case (ld_reg)
                LD_IDLE:
                    ld_reg <= LD_IDLE;
                LD_LOW:
                begin
                    lowByte_reg <= ioWrData;   // RULE_11
                    ld_reg      <= LD_HIGH;
                end
                LD_HIGH:
                    ld_reg <= LD_IDLE;
                default:
                    ld_reg <= LD_IDLE;
            endcase
        end
    end

    // Commit of the full 16-bit limits on the high-byte write
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            slaveLimit_reg  <= `BTI_COUNT_RST;
            masterLimit_reg <= `BTI_COUNT_RST;
        end
        else if (!tmrCtrlWr && ld_reg == LD_HIGH)
        begin
            if (slaveWr && tgt_reg == SEL_SLAVE)
                slaveLimit_reg <= joinBytes(ioWrData, lowByte_reg);    // RULE_13
            if (masterWr && tgt_reg == SEL_MASTER)
                masterLimit_reg <= joinBytes(ioWrData, lowByte_reg);   // RULE_17
        end
    end

    // Shared 100 ns tick for both timers
    bti_tick_gen u_tick (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick)
    );

    // Slave-mode timer runs while the card holds the host bus
    bti_hold_timer u_slave_tmr (
        .mclk    (mclk),
        .rst     (rst),
        .tick    (tick),
        .restart (hostGrant && !grantDly_reg),   // RULE_20
        .run     (hostGrant),
        .loadVal (slaveLimit_reg),
        .expired (slaveExpired)
    );

    // Master-mode timer runs while a host cycle is stalled on the expansion bus
    bti_hold_timer u_master_tmr (
        .mclk    (mclk),
        .rst     (rst),
        .tick    (tick),
        .restart (hostCycleStart),   // RULE_20
        .run     (masterXferBusy && !aborted_reg),
        .loadVal (masterLimit_reg),
        .expired (masterExpired)
    );

    // Grant edge detect and bus release; release waits for the transfer
    // in flight so a host cycle is never cut in half
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            grantDly_reg   <= 1'b0;
            hostBusRelease <= 1'b0;
            slaveTo_reg    <= 1'b0;
        end
        else
        begin
            grantDly_reg <= hostGrant;
            if (!hostGrant)
                hostBusRelease <= 1'b0;
            else if (slaveExpired && !slaveXferBusy)
                hostBusRelease <= 1'b1;   // RULE_10
            if (slaveExpired)
                slaveTo_reg <= 1'b1;
            else if (hostGrant && !grantDly_reg)
                slaveTo_reg <= 1'b0;
        end
    end

    // Host cycle abort: one pulse, then the expansion side is left alone
    // until its transfer ends; this block never drives the expansion bus
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hostAbortRetry <= 1'b0;
            aborted_reg    <= 1'b0;
            masterTo_reg   <= 1'b0;
        end
        else
        begin
            hostAbortRetry <= masterExpired && masterXferBusy && !aborted_reg;   // RULE_15
            if (!masterXferBusy)
                aborted_reg <= 1'b0;
            else if (masterExpired)
                aborted_reg <= 1'b1;   // RULE_16
            if (masterExpired && masterXferBusy && !aborted_reg)
                masterTo_reg <= 1'b1;
            else if (hostCycleStart)
                masterTo_reg <= 1'b0;
        end
    end

    // Sticky statuses: a disabled source holds its status clear, so here the
    // clear deliberately wins over an arriving event
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tcStatus_reg    <= 1'b0;
            ownStatus_reg   <= 1'b0;
            pcReqStatus_reg <= 1'b0;
        end
        else
        begin
            if (!ctrl_reg.terminal_count_enable)
                tcStatus_reg <= 1'b0;   // RULE_04
            else if (tcEvent)
                tcStatus_reg <= 1'b1;   // RULE_03
            if (!ctrl_reg.bus_ownership_enable)
                ownStatus_reg <= 1'b0;   // RULE_06
            else if (busOwnedCond)
                ownStatus_reg <= 1'b1;   // RULE_05
            if (!ctrl_reg.pcReqEn)
                pcReqStatus_reg <= 1'b0;
            else if (pcReqEvent)
                pcReqStatus_reg <= 1'b1;
        end
    end

    // Board interrupt equation
    always_comb
    begin
        flag_next = ctrl_reg.boardEn &&   // RULE_18
            (sigReadyCond && ctrl_reg.signal_ready_enable            // RULE_07
             || tcStatus_reg && ctrl_reg.terminal_count_enable       // RULE_03
             || excAny && ctrl_reg.master_exception_enable           // RULE_02
             || expansionIrq && ctrl_reg.expansion_irq_enable        // RULE_01
             || ownStatus_reg                                        // RULE_05
             || pcReqStatus_reg && ctrl_reg.pcReqEn);
    end

    // Flag and interrupt line; the line is released whenever the board
    // enable is off so other cards may share the level
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            boardFlag_reg <= 1'b0;
            boardIrqOe    <= 1'b0;
        end
        else
        begin
            boardFlag_reg <= flag_next;
            boardIrqOe    <= ctrl_reg.boardEn;
        end
    end

    assign boardIrq = boardFlag_reg;

    // Status word seen by the host
    always_comb
    begin
        statusWord                     = `BTI_STAT_RST;
        statusWord[`BTI_ST_SIG_READY]  = sigReadyCond;
        statusWord[`BTI_ST_TC]         = tcStatus_reg;
        statusWord[`BTI_ST_OWN_INT]    = ownStatus_reg;
        statusWord[`BTI_ST_EXC]        = excAny;
        statusWord[`BTI_ST_EXP_IRQ]    = expansionIrq;
        statusWord[`BTI_ST_BOARD_FLAG] = boardFlag_reg;
        statusWord[`BTI_ST_SLAVE_TO]   = slaveTo_reg;
        statusWord[`BTI_ST_MASTER_TO]  = masterTo_reg;
        statusWord[`BTI_ST_BUS_OWNED]  = busOwnedCond;
        statusWord[`BTI_ST_PC_REQ]     = pcReqStatus_reg;
    end

    // Read data, one cycle after the strobe; timer registers are write-only
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ioRdData <= 8'h00;
        else if (ioRead)
        begin
            unique case (ioAddr)
                `BTI_OFS_STAT_LO: ioRdData <= statusWord[7:0];
                `BTI_OFS_STAT_HI: ioRdData <= statusWord[15:8];
                `BTI_OFS_CTRL:    ioRdData <= ctrl_reg;
                default:          ioRdData <= 8'h00;
            endcase
        end
    end

    // Checks
    sequence sSlaveArm;
        tmrCtrlWr && ioWrData[`BTI_SEL_MSB:`BTI_SEL_LSB] == SEL_SLAVE
            && ioWrData[`BTI_MODE_MSB:0] == `BTI_MODE_VAL;
    endsequence

    sequence sByteWrite;
        ioWrite && ioAddr == `BTI_OFS_SLAVE_TMR && !tmrCtrlWr;
    endsequence

    a_irq_sets_flag: assert property (@(posedge mclk) disable iff (rst)   // RULE_01
        ctrl_reg.boardEn && ctrl_reg.expansion_irq_enable && expansionIrq |=> boardIrq)
        else $error("expansion irq did not set the board flag");
    a_exc_sets_flag: assert property (@(posedge mclk) disable iff (rst)   // RULE_02
        ctrl_reg.boardEn && ctrl_reg.master_exception_enable && excAny |=> boardIrq)
        else $error("master exception did not set the board flag");
    a_tc_status_path: assert property (@(posedge mclk) disable iff (rst)   // RULE_03
        ctrl_reg.boardEn && ctrl_reg.terminal_count_enable && tcEvent && !ctrlWr
            |=> tcStatus_reg ##1 boardIrq)
        else $error("terminal count did not reach the board flag");
    a_tc_held_clear: assert property (@(posedge mclk) disable iff (rst)   // RULE_04
        !ctrl_reg.terminal_count_enable |=> !tcStatus_reg)
        else $error("terminal count status set while disabled");
    a_own_status_set: assert property (@(posedge mclk) disable iff (rst)   // RULE_05
        ctrl_reg.bus_ownership_enable && busOwnedCond && !ctrlWr |=> ownStatus_reg)
        else $error("bus ownership did not set its status");
    a_own_held_clear: assert property (@(posedge mclk) disable iff (rst)   // RULE_06
        !ctrl_reg.bus_ownership_enable |=> !ownStatus_reg)
        else $error("ownership status set while disabled");
    a_sig_sets_flag: assert property (@(posedge mclk) disable iff (rst)   // RULE_07
        ctrl_reg.boardEn && ctrl_reg.signal_ready_enable && sigReadyCond |=> boardIrq)
        else $error("signal ready did not set the board flag");
    a_reset_enables: assert property (@(posedge mclk)   // RULE_08
        rst |-> ctrl_reg == bti_ctrl_t'(`BTI_CTRL_RST))
        else $error("enables not cleared by reset");
    a_flag_gated: assert property (@(posedge mclk) disable iff (rst)   // RULE_18
        !ctrl_reg.boardEn |=> !boardIrq)
        else $error("board flag set with board enable off");
    // Fixed spacing of one idle cycle between the three writes keeps a stray
    // third data write from being taken for the high byte
    a_slave_load: assert property (@(posedge mclk) disable iff (rst)   // RULE_13
        sSlaveArm ##1 !ioWrite ##1 sByteWrite ##1 !ioWrite ##1 sByteWrite
            |=> slaveLimit_reg == {$past(ioWrData), $past(ioWrData, 3)})
        else $error("slave limit not loaded low byte then high byte");
    a_slave_release: assert property (@(posedge mclk) disable iff (rst)   // RULE_10
        hostGrant && slaveExpired && !slaveXferBusy |=> hostBusRelease)
        else $error("bus not released after slave timeout");
    a_release_waits: assert property (@(posedge mclk) disable iff (rst)   // RULE_10
        !hostBusRelease && slaveXferBusy |=> !hostBusRelease)
        else $error("bus released during a transfer");
    a_abort_pulse: assert property (@(posedge mclk) disable iff (rst)   // RULE_15
        masterExpired && masterXferBusy && !aborted_reg |=> hostAbortRetry ##1 !hostAbortRetry)
        else $error("host cycle abort not a single pulse");
    a_abort_once: assert property (@(posedge mclk) disable iff (rst)   // RULE_16
        hostAbortRetry |=> (!hostAbortRetry || !masterXferBusy)[*3])
        else $error("repeated abort while expansion transfer continues");
    a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)   // RULE_21
        tick |=> (!tick)[*8])
        else $error("timer tick faster than 100 ns");

endmodule : bti_top
`default_nettype wire

// ==== bti_map.svh ====
// Register offsets, field positions, reset values and timing counts
// for the bus timeout timers and interrupt enable block.
// Assumes an 8-bit host I/O port with a 5-bit byte offset.
`ifndef BTI_MAP_SVH
`define BTI_MAP_SVH

// Host I/O byte offsets
`define BTI_OFS_STAT_LO    5'h00
`define BTI_OFS_STAT_HI    5'h01
`define BTI_OFS_CTRL       5'h02
`define BTI_OFS_SLAVE_TMR  5'h10
`define BTI_OFS_MASTER_TMR 5'h12
`define BTI_OFS_TMR_CTRL   5'h16

// Timer control byte layout
`define BTI_SEL_MSB        7
`define BTI_SEL_LSB        6
`define BTI_MODE_MSB       5
`define BTI_MODE_VAL       6'h34

// Board status bit positions (16-bit status word)
`define BTI_ST_SIG_READY   0
`define BTI_ST_TC          1
`define BTI_ST_OWN_INT     2
`define BTI_ST_EXC         3
`define BTI_ST_EXP_IRQ     4
`define BTI_ST_BOARD_FLAG  5
`define BTI_ST_SLAVE_TO    6
`define BTI_ST_MASTER_TO   7
`define BTI_ST_BUS_OWNED   12
`define BTI_ST_PC_REQ      15

// Reset values
`define BTI_CTRL_RST       8'h00
`define BTI_COUNT_RST      16'hFFFF
`define BTI_BYTE_RST       8'h00
`define BTI_STAT_RST       16'h0000

// Timing: 100 ns timer tick from the 10 ns card clock
`define BTI_CLK_NS         10
`define BTI_TICK_NS        100
`define BTI_TICK_CYCLES    ((`BTI_TICK_NS + `BTI_CLK_NS - 1) / `BTI_CLK_NS)

`endif

// ==== bti_pkg.sv ====
// Types shared by the bus timeout timers and interrupt enable block.
// Assumes bti_map.svh is on the include path.
package bti_pkg;

    // Board control byte: bit 7 board enable, bits 5..0 source enables
    typedef struct packed {
        logic boardEn;
        logic spare;
        logic pcReqEn;
        logic expansion_irq_enable;
        logic master_exception_enable;
        logic terminal_count_enable;
        logic bus_ownership_enable;
        logic signal_ready_enable;
    } bti_ctrl_t;

    // Master-mode exception sources
    typedef struct packed {
        logic parity_error;
        logic deadlock_error;
        logic bus_error_exception;
        logic local_bus_timeout;
    } bti_exc_t;

    // Timer selected by the timer control write
    typedef enum logic [1:0] {
        SEL_SLAVE  = 2'b00,
        SEL_MASTER = 2'b01,
        SEL_SYSCTL = 2'b10,
        SEL_RSVD   = 2'b11
    } bti_sel_t;

    // Two-byte count loading sequence
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_LOW  = 2'b01,
        LD_HIGH = 2'b10
    } bti_load_t;

endpackage : bti_pkg

// ==== bti_tick_gen.sv ====
// Divider making the 100 ns timer tick as a one-cycle enable.
// Assumes mclk runs at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "bti_map.svh"

module bti_tick_gen
    import bti_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Tick enable
    output logic      tick
);

    logic [3:0] divCnt_reg;

    // Free-running divider; wraps after the tick count
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_reg <= 4'h0;
            tick       <= 1'b0;
        end
        else if (divCnt_reg == 4'(`BTI_TICK_CYCLES - 1))
        begin
            divCnt_reg <= 4'h0;
            tick       <= 1'b1;
        end
        else
        begin
            divCnt_reg <= divCnt_reg + 4'h1;
            tick       <= 1'b0;
        end
    end

endmodule : bti_tick_gen
`default_nettype wire

// ==== bti_hold_timer.sv ====
// One 16-bit timeout timer counting 100 ns ticks down to zero.
// Assumes restart is a pulse and run is held for the guarded activity.
`timescale 1ns/1ps
`default_nettype none

module bti_hold_timer
    import bti_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Control
    input  wire logic        tick,
    input  wire logic        restart,
    input  wire logic        run,
    input  wire logic [15:0] loadVal,
    // Expiry level
    output logic             expired
);

    logic [15:0] cnt_reg;
    logic        armed_reg;

    // Restart reloads; otherwise count down one per tick while running
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg   <= 16'h0000;
            armed_reg <= 1'b0;
        end
        else if (restart)
        begin
            cnt_reg   <= loadVal;   // RULE_20
            armed_reg <= 1'b1;
        end
        else if (!run)
            armed_reg <= 1'b0;
        else if (tick && cnt_reg != 16'h0000)
            cnt_reg <= cnt_reg - 16'h0001;   // RULE_21
    end

    // Expiry only while armed, so a stale zero never fires
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            expired <= 1'b0;
        else
            expired <= armed_reg && run && !restart && cnt_reg == 16'h0000;   // RULE_21
    end

endmodule : bti_hold_timer
`default_nettype wire

// ==== bti_host_model.sv ====
// Host bus partner: grants the card the host bus and takes it back on request.
// Assumes the bench asks for the bus by a level, driven on falling edges.
`timescale 1ns/1ps
`default_nettype none
module bti_host_model
    import bti_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Bench requests
    input  wire logic wantBus,
    input  wire logic holdXfer,
    // Card side
    input  wire logic hostBusRelease,
    output logic      hostGrant,
    output logic      slaveXferBusy
);
    // Grant while wanted, withdrawn as soon as the card gives the bus back
    always @(posedge mclk or posedge rst)
        if (rst)
            hostGrant <= 1'b0;
        else
            hostGrant <= wantBus && !hostBusRelease;
    // A transfer can only be busy while the card owns the bus
    assign slaveXferBusy = holdXfer && hostGrant;
endmodule : bti_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the interrupt enables and the two timeout timers.
// Assumes a 10-cycle timer tick; inputs change on falling edges only, apart from the first reset rise.
`timescale 1ns/1ps
`default_nettype none
`include "bti_map.svh"
module tb_top;
    import bti_pkg::*;
    logic mclk = 1'b0, rst = 1'b0, ioWrite = 1'b0, ioRead = 1'b0;
    logic [4:0] ioAddr = 5'h00;
    logic [7:0] ioWrData = 8'h00, ioRdData, d;
    logic sigReadyCond = 0, tcEvent = 0, expansionIrq = 0, busOwnedCond = 0;
    logic hostCycleStart = 0, masterXferBusy = 0, wantBus = 0, holdXfer = 0;
    logic hostGrant, slaveXferBusy, hostBusRelease, hostAbortRetry, boardIrq, boardIrqOe;
    bti_exc_t exceptions = '0;
    int err_total = 0, num_checks = 0, n;

    always #5 mclk = ~mclk;

    bti_top i_bti_top (.mclk(mclk), .rst(rst), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .sigReadyCond(sigReadyCond), .tcEvent(tcEvent), .exceptions(exceptions),
        .expansionIrq(expansionIrq), .busOwnedCond(busOwnedCond), .pcReqEvent(1'b0),
        .hostGrant(hostGrant), .slaveXferBusy(slaveXferBusy),
        .hostBusRelease(hostBusRelease), .hostCycleStart(hostCycleStart),
        .masterXferBusy(masterXferBusy), .hostAbortRetry(hostAbortRetry),
        .boardIrq(boardIrq), .boardIrqOe(boardIrqOe));
    bti_host_model i_bti_host_model (.mclk(mclk), .rst(rst), .wantBus(wantBus),
        .holdXfer(holdXfer), .hostBusRelease(hostBusRelease), .hostGrant(hostGrant),
        .slaveXferBusy(slaveXferBusy));

    // Comparison with count; four-state compare so unknowns never match
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic idle(input int c);
        repeat (c) @(negedge mclk);
    endtask : idle
    // One-cycle write and read strobes on the host I/O port
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(negedge mclk);
        ioWrite = 1'b1; ioAddr = a; ioWrData = v;
        @(negedge mclk);
        ioWrite = 1'b0; ioWrData = ~v;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(negedge mclk);
        ioRead = 1'b1; ioAddr = a;
        @(negedge mclk);
        ioRead = 1'b0;
        d = ioRdData;
    endtask : rd
    // Bounded wait for a timer outcome: 0 = bus release, 1 = abort
    task automatic waitFor(input bit which);
        for (n = 0; n < 300; n++)
        begin
            @(negedge mclk);
            if ((which ? hostAbortRetry : hostBusRelease) === 1'b1)
                break;
        end
    endtask : waitFor
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // Enables set, then a second reset in mid-run must clear them
    task automatic t_reset;
        wr(5'h02, 8'h1F);
        rst = 1'b1; idle(2); rst = 1'b0;
        rd(5'h02); chk("ctrl after reset", 16'h0000, d);
        $display("test reset done");
    endtask : t_reset
    // Direct conditions: signal ready, exception, expansion IRQ
    task automatic t_direct;
        logic [7:0] en [3] = '{8'h01, 8'h08, 8'h10};
        for (int k = 0; k < 3; k++)
        begin
            wr(5'h02, 8'h80);
            sigReadyCond = (k == 0); exceptions.deadlock_error = (k == 1); expansionIrq = (k == 2);
            idle(3);
            if (k > 0) chk("irq masked", 16'h0000, boardIrq);
            wr(5'h02, 8'h80 | en[k]); idle(3);
            chk("irq direct", 16'h0003, {boardIrq, boardIrqOe});
            wr(5'h02, en[k]); idle(3);
            chk("irq board off", 16'h0000, {boardIrq, boardIrqOe});
            sigReadyCond = 0; exceptions = '0; expansionIrq = 0;
        end
        $display("test direct done");
    endtask : t_direct
    // Sticky statuses: terminal count (bit 1) and bus ownership (bit 2)
    task automatic t_sticky;
        for (int k = 0; k < 2; k++)
        begin
            wr(5'h02, k ? 8'h82 : 8'h84);
            @(negedge mclk); tcEvent = !k; busOwnedCond = k;
            @(negedge mclk); tcEvent = 0; busOwnedCond = 0;
            idle(3); rd(5'h00);
            chk("status set", k ? 16'h4 : 16'h2, d & (k ? 8'h04 : 8'h02));
            chk("irq sticky", 16'h0001, boardIrq);
            wr(5'h02, 8'h80);
            @(negedge mclk); tcEvent = !k; busOwnedCond = k;
            @(negedge mclk); tcEvent = 0; busOwnedCond = 0;
            idle(3); rd(5'h00);
            chk("status cleared", 16'h0000, d & 8'h06);
            chk("irq cleared", 16'h0000, boardIrq);
        end
        $display("test sticky done");
    endtask : t_sticky
    // Slave hold limit of 5 ticks: held off by a busy transfer, then timed
    task automatic t_slave;
        wr(5'h16, 8'h34); wr(5'h10, 8'h05); wr(5'h10, 8'h00);
        wantBus = 1; holdXfer = 1; idle(80);
        chk("release while busy", 16'h0000, hostBusRelease);
        holdXfer = 0; idle(2);
        chk("release after xfer", 16'h0001, hostBusRelease);
        wantBus = 0; idle(3); wantBus = 1; waitFor(0);
        chk("slave limit", 16'h0001, n >= 40 && n <= 56);
        rd(5'h00);
        chk("slave timeout seen", 16'h0040, d & 8'h40);
        wantBus = 0; idle(3);
        $display("test slave done");
    endtask : t_slave
    // Master stall limit of 3 ticks; a system-controller select must not touch it
    task automatic t_master;
        wr(5'h16, 8'h74); wr(5'h12, 8'h03); wr(5'h12, 8'h00);
        wr(5'h16, 8'hB4); wr(5'h12, 8'h40); wr(5'h12, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            @(negedge mclk); hostCycleStart = 1; masterXferBusy = 1;
            @(negedge mclk); hostCycleStart = 0;
            waitFor(1);
            chk("master limit", 16'h0001, n >= 20 && n <= 36);
            waitFor(1);
            chk("single abort", 16'h0001, n == 300);
            masterXferBusy = 0; idle(2);
        end
        rd(5'h00);
        chk("master timeout seen", 16'h0080, d & 8'h80);
        @(negedge mclk); hostCycleStart = 1; masterXferBusy = 1;
        @(negedge mclk); hostCycleStart = 0; idle(5); masterXferBusy = 0;
        waitFor(1);
        chk("no abort when done", 16'h0001, n == 300);
        rd(5'h00);
        chk("master timeout clear", 16'h0000, d & 8'h80);
        $display("test master done");
    endtask : t_master

    // Reset rises just after time zero so the asynchronous branch sees an edge
    initial
    begin
        #1;
        rst = 1'b1;
        idle(20);
        rst = 1'b0;
        t_reset();
        t_direct();
        t_sticky();
        t_slave();
        t_master();
        summarize();
    end
    // Whole run is about 1250 cycles; this cuts a hang
    initial
    begin
        #200000;
        err_total++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
